// file: pkg/fcs_map.vh
`ifndef FCS_MAP_VH
`define FCS_MAP_VH

// ****************************************
// Command codes and fields
// ****************************************
`define FCS_OP_MASK 8'h1F
`define FCS_OP_READ 8'h06
`define FCS_OP_READ_DEL 8'h0C
`define FCS_OP_PERP 8'h12
`define FCS_BIT_MULTI_TRACK 7
`define FCS_BIT_DENSITY 6
`define FCS_BIT_PASS_DEL 5
`define FCS_BIT_HEAD_SEL 2
`define FCS_READ_CMD_LEN 4'h9
`define FCS_PERP_CMD_LEN 4'h2
`define FCS_READ_RES_LEN 3'h7
`define FCS_STAT0_INVALID 8'h80
`define FCS_STAT0_ABNORMAL 8'h40
`define FCS_STAT2_CTRL_MARK 8'h40
`define FCS_STAT1_END_CYL 8'h80

// ****************************************
// Reset values
// ****************************************
`define FCS_RST_QEN 1'b0
`define FCS_RST_QTHR 4'h0
`define FCS_RST_PTRK 8'h00

// ****************************************
// Data rates, timing and sector size
// ****************************************
`define FCS_CLK_HZ 25000000
`define FCS_RATE_500K 2'b00
`define FCS_RATE_250K 2'b01
`define FCS_RATE_1M 2'b10
`define FCS_RATE_2M 2'b11
`define FCS_BPS_500K 500000
`define FCS_BPS_250K 250000
`define FCS_BPS_1M 1000000
`define FCS_BPS_2M 2000000
`define FCS_SIZE_BASE 15'h0080

`endif

// file: rtl/fcs_command_sequencer.v
`timescale 1ns/1ps
`include "fcs_map.vh"
module fcs_command_sequencer #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  input wire softReset,
  // Host command and result bytes
  input wire [7:0] cmdData,
  input wire cmdValid,
  output wire cmdReady,
  output reg [7:0] resData,
  output wire resValid,
  input wire resReady,
  // Main status bits
  output wire requestForMaster,
  output wire transferDirection,
  output wire busy,
  // Configuration
  input wire cfgLoad,
  input wire cfgQueueEnable,
  input wire [3:0] cfgQueueThreshold,
  input wire [7:0] cfgPrecompStartTrack,
  input wire cfgRetain,
  output reg queueEnable,
  output reg [3:0] queueThreshold,
  output reg [7:0] precompStartTrack,
  input wire [1:0] dataRate,
  output reg [7:0] bitCellCycles,
  output reg perpMode,
  output wire rateFault,
  // Drive sector interface
  output reg sectorReq,
  output reg [8:0] sectorCyl,
  output reg sectorHead,
  output reg [7:0] sectorRec,
  output reg [1:0] driveSelect,
  output reg densitySelect,
  input wire [7:0] diskData,
  input wire diskValid,
  output wire diskReady,
  input wire diskDeleted,
  // Sector data toward host
  output wire [7:0] hostData,
  output wire hostValid,
  input wire hostReady,
  // Write precompensation
  input wire wrBit,
  input wire wrBitStrobe,
  output reg wrBitOut,
  output reg wrEarly,
  output reg wrLate
);

  localparam ST_IDLE = 3'd0;
  localparam ST_CMD = 3'd1;
  localparam ST_REQ = 3'd2;
  localparam ST_XFER = 3'd3;
  localparam ST_RES = 3'd4;
  localparam [31:0] CELLS_500K = `FCS_CLK_HZ / `FCS_BPS_500K;
  localparam [31:0] CELLS_250K = `FCS_CLK_HZ / `FCS_BPS_250K;
  localparam [31:0] CELLS_1M = `FCS_CLK_HZ / `FCS_BPS_1M;
  localparam [31:0] CELLS_2M = `FCS_CLK_HZ / `FCS_BPS_2M;

  // ****************************************
  // Helpers
  // ****************************************
  function [7:0] cells;
    input [1:0] rate;
    begin
      if (rate == `FCS_RATE_250K)
        cells = CELLS_250K[7:0];
      else if (rate == `FCS_RATE_1M)
        cells = CELLS_1M[7:0];
      else if (rate == `FCS_RATE_2M)
        cells = CELLS_2M[7:0];
      else
        cells = CELLS_500K[7:0];
    end
  endfunction

  function [14:0] secLen;
    input [7:0] sizeCode;
    input [7:0] dataLen;
    begin
      if (sizeCode == 8'h00)
        secLen = {7'h00, dataLen};
      else if (sizeCode > 8'h07)
        secLen = `FCS_SIZE_BASE << 7;
      else
        secLen = `FCS_SIZE_BASE << sizeCode[2:0];
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [2:0] state_ff;
  reg [3:0] byteIdx_ff;
  reg [3:0] cmdLen_ff;
  reg [2:0] resLen_ff;
  reg [7:0] opcode_ff;
  reg [7:0] sizeCode_ff;
  reg [7:0] lastSec_ff;
  reg [7:0] gapLen_ff;
  reg [7:0] dataLen_ff;
  reg [7:0] stat0_ff;
  reg [7:0] stat1_ff;
  reg [7:0] stat2_ff;
  reg [14:0] xferCnt_ff;
  reg skipSector_ff;
  reg stopAfter_ff;
  reg [2:0] wrHist_ff;
  wire cmdTake;
  wire resTake;
  wire fifoInValid;
  wire wantDeleted;
  wire markMismatch;
  wire isRead;
  wire [7:0] low5;
  wire fifoInReady;
  wire firstByte;
  wire skipNow;
  wire stopNow;

  assign low5 = cmdData & `FCS_OP_MASK;
  assign isRead = ((opcode_ff & `FCS_OP_MASK) == `FCS_OP_READ) |
                  ((opcode_ff & `FCS_OP_MASK) == `FCS_OP_READ_DEL);

  // ****************************************
  // Host handshake and main status
  // ****************************************
  assign requestForMaster = (state_ff == ST_IDLE) | (state_ff == ST_CMD) |
                            (state_ff == ST_RES);
  assign transferDirection = (state_ff == ST_RES);
  assign cmdReady = requestForMaster & ~transferDirection;
  assign resValid = (state_ff == ST_RES);
  assign busy = (state_ff != ST_IDLE);
  assign cmdTake = cmdValid & cmdReady;
  assign resTake = resValid & resReady;
  assign rateFault = perpMode & (dataRate != `FCS_RATE_1M);

  // ****************************************
  // Sector data path
  // ****************************************
  assign wantDeleted = ((opcode_ff & `FCS_OP_MASK) == `FCS_OP_READ_DEL);
  assign markMismatch = diskDeleted ^ wantDeleted;
  // First byte of a skipped sector must not reach the queue either
  assign firstByte = (xferCnt_ff == 15'h0000);
  assign skipNow = skipSector_ff | (firstByte & markMismatch & opcode_ff[`FCS_BIT_PASS_DEL]);
  assign stopNow = stopAfter_ff | (firstByte & markMismatch & ~opcode_ff[`FCS_BIT_PASS_DEL]);
  assign fifoInValid = (state_ff == ST_XFER) & diskValid & ~skipNow;

  fcs_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .inData(diskData),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .outData(hostData),
    .outValid(hostValid),
    .outReady(hostReady),
    .flush(softReset | (state_ff == ST_CMD))
  );

  assign diskReady = (state_ff == ST_XFER) & (fifoInReady | skipNow);

  // ****************************************
  // Configuration and mode
  // ****************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      queueEnable <= `FCS_RST_QEN;
      queueThreshold <= `FCS_RST_QTHR;
      precompStartTrack <= `FCS_RST_PTRK;
      bitCellCycles <= 8'h00;
    end
    else
    begin
      bitCellCycles <= cells(dataRate);
      if (softReset & ~cfgRetain)
      begin
        queueEnable <= `FCS_RST_QEN;
        queueThreshold <= `FCS_RST_QTHR;
        precompStartTrack <= `FCS_RST_PTRK;
      end
      else if (cfgLoad)
      begin
        queueEnable <= cfgQueueEnable;
        queueThreshold <= cfgQueueThreshold;
        precompStartTrack <= cfgPrecompStartTrack;
      end
    end
  end

  // ****************************************
  // Write precompensation
  // ****************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrHist_ff <= 3'h0;
      wrBitOut <= 1'b0;
      wrEarly <= 1'b0;
      wrLate <= 1'b0;
    end
    else if (wrBitStrobe)
    begin
      wrHist_ff <= {wrHist_ff[1:0], wrBit};
      wrBitOut <= wrHist_ff[0];
      if (sectorCyl >= {1'b0, precompStartTrack})
      begin
        wrEarly <= ({wrHist_ff[1:0], wrBit} == 3'b110);
        wrLate <= ({wrHist_ff[1:0], wrBit} == 3'b011);
      end
      else
      begin
        wrEarly <= 1'b0;
        wrLate <= 1'b0;
      end
    end
  end

  // ****************************************
  // Result byte selection
  // ****************************************
  always @*
  begin
    case (byteIdx_ff)
      4'd0: resData = stat0_ff;
      4'd1: resData = stat1_ff;
      4'd2: resData = stat2_ff;
      4'd3: resData = sectorCyl[7:0];
      4'd4: resData = {7'h00, sectorHead};
      4'd5: resData = sectorRec;
      4'd6: resData = sizeCode_ff;
      default: resData = 8'h00;
    endcase
  end

  // ****************************************
  // Command sequencer
  // ****************************************
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE;
      byteIdx_ff <= 4'h0;
      cmdLen_ff <= 4'h0;
      resLen_ff <= 3'h0;
      opcode_ff <= 8'h00;
      sizeCode_ff <= 8'h00;
      lastSec_ff <= 8'h00;
      gapLen_ff <= 8'h00;
      dataLen_ff <= 8'h00;
      stat0_ff <= 8'h00;
      stat1_ff <= 8'h00;
      stat2_ff <= 8'h00;
      xferCnt_ff <= 15'h0000;
      skipSector_ff <= 1'b0;
      stopAfter_ff <= 1'b0;
      sectorReq <= 1'b0;
      sectorCyl <= 9'h000;
      sectorHead <= 1'b0;
      sectorRec <= 8'h00;
      driveSelect <= 2'b00;
      densitySelect <= 1'b0;
      perpMode <= 1'b0;
    end
    else if (softReset)
    begin
      state_ff <= ST_IDLE;
      byteIdx_ff <= 4'h0;
      sectorReq <= 1'b0;
      perpMode <= 1'b0;
    end
    else
    begin
      sectorReq <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          if (cmdTake)
          begin
            opcode_ff <= cmdData;
            byteIdx_ff <= 4'h1;
            stat0_ff <= 8'h00;
            stat1_ff <= 8'h00;
            stat2_ff <= 8'h00;
            if ((low5 == `FCS_OP_READ) | (low5 == `FCS_OP_READ_DEL))
            begin
              cmdLen_ff <= `FCS_READ_CMD_LEN;
              state_ff <= ST_CMD;
            end
            else if (cmdData == `FCS_OP_PERP)
            begin
              cmdLen_ff <= `FCS_PERP_CMD_LEN;
              state_ff <= ST_CMD;
            end
            else
            begin
              stat0_ff <= `FCS_STAT0_INVALID;
              resLen_ff <= 3'h1;
              byteIdx_ff <= 4'h0;
              state_ff <= ST_RES;
            end
          end
        end
        ST_CMD:
        begin
          if (cmdTake)
          begin
            byteIdx_ff <= byteIdx_ff + 4'h1;
            if (!isRead)
              perpMode <= cmdData[0];
            else
            begin
              case (byteIdx_ff)
                4'd1:
                begin
                  sectorHead <= cmdData[`FCS_BIT_HEAD_SEL];
                  driveSelect <= cmdData[1:0];
                end
                4'd2: sectorCyl <= {1'b0, cmdData};
                4'd3: sectorHead <= cmdData[0];
                4'd4: sectorRec <= cmdData;
                4'd5: sizeCode_ff <= cmdData;
                4'd6: lastSec_ff <= cmdData;
                4'd7: gapLen_ff <= cmdData;
                default: dataLen_ff <= cmdData;
              endcase
            end
            if (byteIdx_ff == cmdLen_ff - 4'h1)
            begin
              byteIdx_ff <= 4'h0;
              densitySelect <= opcode_ff[`FCS_BIT_DENSITY];
              if (isRead)
              begin
                sectorReq <= 1'b1;
                state_ff <= ST_XFER;
              end
              else
              begin
                resLen_ff <= 3'h0;
                state_ff <= ST_IDLE;
              end
            end
          end
        end
        ST_REQ:
        begin
          sectorReq <= 1'b1;
          state_ff <= ST_XFER;
        end
        ST_XFER:
        begin
          if (diskValid & diskReady)
          begin
            if (firstByte)
            begin
              skipSector_ff <= skipNow;
              if (stopNow)
              begin
                stat2_ff <= stat2_ff | `FCS_STAT2_CTRL_MARK;
                stopAfter_ff <= 1'b1;
              end
            end
            if (xferCnt_ff == secLen(sizeCode_ff, dataLen_ff) - 15'h0001)
            begin
              xferCnt_ff <= 15'h0000;
              skipSector_ff <= 1'b0;
              if (stopNow | (sectorRec == lastSec_ff))
              begin
                stopAfter_ff <= 1'b0;
                if (sectorRec == lastSec_ff)
                begin
                  sectorRec <= 8'h01;
                  if (opcode_ff[`FCS_BIT_MULTI_TRACK] & ~sectorHead)
                    sectorHead <= 1'b1;
                  else if (sectorCyl != 9'h100)
                  begin
                    sectorCyl <= sectorCyl + 9'h001;
                    sectorHead <= 1'b0;
                  end
                  else
                    stat1_ff <= `FCS_STAT1_END_CYL;
                end
                if ((sectorRec == lastSec_ff) & opcode_ff[`FCS_BIT_MULTI_TRACK] &
                    ~sectorHead & ~stopNow)
                  state_ff <= ST_REQ;
                else
                begin
                  resLen_ff <= `FCS_READ_RES_LEN;
                  state_ff <= ST_RES;
                end
              end
              else
              begin
                sectorRec <= sectorRec + 8'h01;
                state_ff <= ST_REQ;
              end
            end
            else
              xferCnt_ff <= xferCnt_ff + 15'h0001;
          end
        end
        ST_RES:
        begin
          if (resTake)
          begin
            if (byteIdx_ff == {1'b0, resLen_ff} - 4'h1)
            begin
              byteIdx_ff <= 4'h0;
              state_ff <= ST_IDLE;
            end
            else
              byteIdx_ff <= byteIdx_ff + 4'h1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule

// file: rtl/fcs_fifo.v
`timescale 1ns/1ps
module fcs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Fill side
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  // Drain side
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady,
  // Flush
  input wire flush
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0] count_ff;
  wire doWr;
  wire doRd;

  assign inReady = (count_ff != DEPTH[AW:0]);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign outData = mem_ff[rdPtr_ff];
  assign doWr = inValid & inReady;
  assign doRd = outValid & outReady;

  always @(posedge clk)
  begin
    if (doWr)
      mem_ff[wrPtr_ff] <= inData;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doWr)
        wrPtr_ff <= (wrPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_ff + 1'b1;
      if (doRd)
        rdPtr_ff <= (rdPtr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_ff + 1'b1;
      if (doWr & ~doRd)
        count_ff <= count_ff + 1'b1;
      else if (doRd & ~doWr)
        count_ff <= count_ff - 1'b1;
    end
  end

endmodule

// file: verification/fcs_command_sequencer_assertions.sv
`timescale 1ns/1ps
module fcs_command_sequencer_assertions (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Watched ports
  input wire softReset,
  input wire cmdReady,
  input wire [7:0] resData,
  input wire resValid,
  input wire resReady,
  input wire requestForMaster,
  input wire transferDirection,
  input wire cfgLoad,
  input wire cfgRetain,
  input wire queueEnable,
  input wire [3:0] queueThreshold,
  input wire [7:0] precompStartTrack,
  input wire [1:0] dataRate,
  input wire [7:0] bitCellCycles,
  input wire perpMode,
  input wire rateFault,
  input wire sectorReq,
  input wire wrEarly,
  input wire wrLate
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence sHeld;
    resValid && !resReady;
  endsequence
  sequence sKeep;
    softReset && cfgRetain && !cfgLoad;
  endsequence
  a_ready_from_status: assert property (cmdReady == (requestForMaster && !transferDirection))
    else $error("command ready disagrees with status");
  a_result_direction: assert property (resValid |-> transferDirection && requestForMaster)
    else $error("result offered while not in result phase");
  a_result_holds: assert property (sHeld |=> resValid && $stable(resData))
    else $error("result byte changed before taken");
  a_sector_pulse: assert property (sectorReq |-> !cmdReady ##1 !sectorReq)
    else $error("sector request not a lone pulse in execution");
  a_rate_fault: assert property (rateFault == (perpMode && dataRate != 2'b10))
    else $error("rate fault wrong");
  a_cell_count: assert property ($past(nrst) && $stable(dataRate) |->
    bitCellCycles == (dataRate == 2'b00 ? 8'h32 : dataRate == 2'b01 ? 8'h64 :
    dataRate == 2'b10 ? 8'h19 : 8'h0C))
    else $error("bit cell count wrong");
  a_soft_keep: assert property (sKeep |=> $stable(queueEnable) &&
    $stable(queueThreshold) && $stable(precompStartTrack))
    else $error("settings lost on retained soft reset");
  a_soft_clear: assert property (softReset && !cfgRetain && !cfgLoad |=>
    !queueEnable && queueThreshold == 4'h0 && precompStartTrack == 8'h00)
    else $error("settings kept on plain soft reset");
  a_perp_clear: assert property (softReset |=> !perpMode)
    else $error("perpendicular mode survived soft reset");
  a_precomp_excl: assert property (!(wrEarly && wrLate))
    else $error("early and late together");
endmodule
bind fcs_command_sequencer fcs_command_sequencer_assertions fcs_command_sequencer_assertions_inst (
  .clk, .nrst, .softReset, .cmdReady, .resData, .resValid, .resReady, .requestForMaster,
  .transferDirection, .cfgLoad, .cfgRetain, .queueEnable, .queueThreshold, .precompStartTrack,
  .dataRate, .bitCellCycles, .perpMode, .rateFault, .sectorReq, .wrEarly, .wrLate);

// file: verification/fcs_drive_model.sv
`timescale 1ns/1ps
module fcs_drive_model (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Sector request and format
  input wire sectorReq,
  input wire [7:0] sectorRec,
  input wire [15:0] secLen,
  input wire [7:0] delRec,
  input wire slow,
  // Byte stream
  output logic [7:0] diskData,
  output logic diskValid,
  input wire diskReady,
  output logic diskDeleted
);
  logic [15:0] cnt;
  logic [7:0] base;
  always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      diskData <= 8'h00;
      diskValid <= 1'b0;
      diskDeleted <= 1'b0;
      cnt <= 16'h0000;
      base <= 8'h00;
    end
    else if (sectorReq)
    begin
      cnt <= 16'h0001;
      base <= {sectorRec[3:0], 4'h0};
      diskData <= {sectorRec[3:0], 4'h0};
      diskValid <= 1'b1;
      diskDeleted <= (sectorRec == delRec);
    end
    else if (diskValid && diskReady)
    begin
      diskDeleted <= 1'b0;
      if (cnt < secLen && !slow)
      begin
        diskData <= base + cnt[7:0];
        cnt <= cnt + 16'h0001;
      end
      else
      begin
        // Released line shows inverted data
        diskValid <= 1'b0;
        diskData <= ~diskData;
      end
    end
    else if (!diskValid && cnt != 16'h0000 && cnt < secLen)
    begin
      diskValid <= 1'b1;
      diskData <= base + cnt[7:0];
      cnt <= cnt + 16'h0001;
    end
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic softReset = 1'b0;
  logic [7:0] cmdData = 8'h00;
  logic cmdValid = 1'b0;
  logic resReady = 1'b0;
  logic cfgLoad = 1'b0;
  logic cfgQueueEnable = 1'b0;
  logic [3:0] cfgQueueThreshold = 4'h0;
  logic [7:0] cfgPrecompStartTrack = 8'h00;
  logic cfgRetain = 1'b0;
  logic [1:0] dataRate = 2'b10;
  logic hostReady = 1'b0;
  logic wrBit = 1'b0;
  logic wrBitStrobe = 1'b0;
  logic [15:0] secLen = 16'h0100;
  logic [7:0] delRec = 8'h00;
  logic slow = 1'b0;
  wire cmdReady, resValid, requestForMaster, transferDirection, busy, queueEnable;
  wire perpMode, rateFault, sectorReq, sectorHead, densitySelect, diskValid, diskReady;
  wire diskDeleted, hostValid, wrBitOut, wrEarly, wrLate;
  wire [7:0] resData, precompStartTrack, bitCellCycles, sectorRec, diskData, hostData;
  wire [3:0] queueThreshold;
  wire [8:0] sectorCyl;
  wire [1:0] driveSelect;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int reqs = 0;
  int e, l, o, i;
  logic [7:0] res [0:6];
  logic [7:0] cellTab [0:3] = '{8'h32, 8'h64, 8'h19, 8'h0C};
  logic [8:0] capCyl;
  logic [2:0] capSel;
  always #20 clk = ~clk;
  fcs_command_sequencer fcs_command_sequencer_inst (.clk, .nrst, .softReset, .cmdData,
    .cmdValid, .cmdReady, .resData, .resValid, .resReady, .requestForMaster,
    .transferDirection, .busy, .cfgLoad, .cfgQueueEnable, .cfgQueueThreshold,
    .cfgPrecompStartTrack, .cfgRetain, .queueEnable, .queueThreshold, .precompStartTrack,
    .dataRate, .bitCellCycles, .perpMode, .rateFault, .sectorReq, .sectorCyl, .sectorHead,
    .sectorRec, .driveSelect, .densitySelect, .diskData, .diskValid, .diskReady,
    .diskDeleted, .hostData, .hostValid, .hostReady, .wrBit, .wrBitStrobe, .wrBitOut,
    .wrEarly, .wrLate);
  fcs_drive_model fcs_drive_model_inst (.clk, .nrst, .sectorReq, .sectorRec, .secLen,
    .delRec, .slow, .diskData, .diskValid, .diskReady, .diskDeleted);
  // ****
  // Tasks
  // ****
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task send(input logic [7:0] b);
    int n;
    n = 0;
    while ((requestForMaster !== 1'b1 || transferDirection !== 1'b0) && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 500)
      failures++;
    cmdData = b;
    cmdValid = 1'b1;
    @(negedge clk);
  endtask
  task cmd9(input logic [71:0] v);
    for (int k = 0; k < 9; k++)
      send(v[71 - 8 * k -: 8]);
    cmdValid = 1'b0;
  endtask
  task getRes(input int n);
    int k, t;
    k = 0;
    t = 0;
    resReady = 1'b1;
    while (k < n && t < 3000)
    begin
      if (resValid === 1'b1)
      begin
        res[k] = resData;
        k++;
      end
      @(negedge clk);
      t++;
    end
    resReady = 1'b0;
    chk("resultBytes", n, k);
  endtask
  task drain(input int n, input int first, input int nsec);
    int k, t;
    logic [7:0] x;
    k = 0;
    t = 0;
    hostReady = 1'b1;
    while (k < n * nsec && t < 3000)
    begin
      if (hostValid === 1'b1)
      begin
        x = ((first + k / n) << 4) + k % n;
        chk("hostData", x, hostData);
        k++;
      end
      @(negedge clk);
      t++;
    end
    hostReady = 1'b0;
    chk("hostBytes", n * nsec, k);
  endtask
  always @(posedge clk)
    if (sectorReq === 1'b1)
    begin
      capCyl <= sectorCyl;
      capSel <= {sectorHead, driveSelect};
      reqs <= reqs + 1;
    end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      give_verdict;
    end
  end
  initial
  begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    e = 0;
    l = 0;
    o = 0;
    for (i = 0; i < 6; i++)
    begin
      wrBit = (i == 1 || i == 2);
      wrBitStrobe = 1'b1;
      @(negedge clk);
      wrBitStrobe = 1'b0;
      repeat (2) @(negedge clk);
      e += (wrEarly === 1'b1);
      l += (wrLate === 1'b1);
      o += (wrBitOut === 1'b1);
    end
    chk("early", 1, e);
    chk("late", 1, l);
    chk("bitOut", 2, o);
    cfgQueueEnable = 1'b1;
    cfgQueueThreshold = 4'hA;
    cfgPrecompStartTrack = 8'h28;
    cfgLoad = 1'b1;
    @(negedge clk);
    cfgLoad = 1'b0;
    cfgRetain = 1'b1;
    softReset = 1'b1;
    @(negedge clk);
    softReset = 1'b0;
    @(negedge clk);
    chk("keep", 16'h1A28, {queueEnable, queueThreshold, precompStartTrack});
    cfgRetain = 1'b0;
    softReset = 1'b1;
    @(negedge clk);
    softReset = 1'b0;
    @(negedge clk);
    chk("clear", 16'h0000, {queueEnable, queueThreshold, precompStartTrack});
    for (i = 0; i < 4; i++)
    begin
      dataRate = i;
      repeat (2) @(negedge clk);
      chk("cells", cellTab[i], bitCellCycles);
    end
    dataRate = 2'b00;
    send(8'h12);
    send(8'h01);
    cmdValid = 1'b0;
    repeat (2) @(negedge clk);
    chk("perp", 16'h0003, {perpMode, rateFault});
    dataRate = 2'b10;
    @(negedge clk);
    chk("rateFault", 0, rateFault);
    cmd9(72'h46_0505_0101_0101_1B28);
    repeat (80) @(negedge clk);
    chk("stall", 16'h0001, {diskReady, hostValid});
    chk("select", 16'h0285, {capCyl, 4'h0, capSel});
    chk("density", 1, densitySelect);
    drain(256, 1, 1);
    getRes(7);
    chk("stat0", 0, res[0]);
    chk("stat2", 0, res[2]);
    chk("chn", 16'h0600, {res[3], res[4]});
    chk("size", 1, res[6]);
    secLen = 16'h0004;
    slow = 1'b1;
    delRec = 8'h01;
    i = reqs;
    cmd9(72'h66_000A_0001_0002_1B04);
    drain(4, 2, 1);
    getRes(7);
    chk("sectors", 2, reqs - i);
    chk("cylSk", 16'h000B, {res[0], res[3]});
    slow = 1'b0;
    cmd9(72'h4C_000C_0001_0001_1B04);
    drain(4, 1, 1);
    getRes(7);
    chk("stat2Del", 0, res[2]);
    delRec = 8'h00;
    cmd9(72'h4C_000D_0001_0001_1B04);
    getRes(7);
    chk("stat2Mark", 16'h0040, res[2]);
    send(8'h1F);
    cmdValid = 1'b0;
    getRes(1);
    chk("invalid", 16'h0080, res[0]);
    @(negedge clk);
    chk("idle", 16'h0002, {resValid, requestForMaster, busy});
    give_verdict;
  end
endmodule
